/* prom_programmer_unit_pkg.sv */
// constants shared by the word programmer and its pulse sequencer
//
// Contract
// - hold 12-bit address and 16-bit data
// - load-data copies all sixteen bits, then flags
// - address load takes bits 0-11 only
// - shift left; ones pulse, zeros skip
// - one bit 20 ms, zero bit 400 ns
// - high address bits pick bank, pulse enable
// - full address to board latch simultaneously
// - hold address 5 ms after last bit
// - set done, then 5 ms readback window
// - start sets busy, clears done, starts cycle; while busy or in the hold window it sets busy but starts none
// - clear resets busy and done
// - pulse clears done only
// - verify returns board data unlatched, then flags
// - respond to jumpered six-bit device code
// - controller handles busy, done, interrupt
package prom_programmer_unit_pkg;

  // ----------------------------------------------------------------
  // bus fields and codes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned ADDR_LSB    = 0;
  localparam int unsigned BANK_W      = 3;
  localparam int unsigned DEVCODE_W   = 6;
  localparam logic [DEVCODE_W-1:0] DEVCODE_NORMAL = 6'h05;
  localparam int unsigned MASK_BIT    = 15;

  typedef enum logic [1:0] {
    FLAG_NONE,
    FLAG_START,
    FLAG_CLEAR,
    FLAG_PULSE
  } flag_fn_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned ONE_BIT_MS  = 20;
  localparam int unsigned ZERO_BIT_NS = 400;
  localparam int unsigned HOLD_MS     = 5;
  localparam int unsigned ONE_BIT_CYC = ONE_BIT_MS * (CLK_HZ / 1000);
  localparam int unsigned ZERO_BIT_CYC =
    (ZERO_BIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HOLD_CYC    = HOLD_MS * (CLK_HZ / 1000);

endpackage : prom_programmer_unit_pkg

/* prom_bit_timer.sv */
// per-step timer for one bit slot or the hold interval
`timescale 1ns/100ps
`default_nettype none
module prom_bit_timer #(
  parameter int unsigned CNT_W = 24
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] count_i,
  // status
  output logic                  expired_o
);
  logic [CNT_W-1:0] count_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (load_i) begin
      count_reg <= count_i;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired_o = (count_reg == '0) && !load_i;
endmodule : prom_bit_timer
`default_nettype wire

/* prom_word_programmer.sv */
// programmed-io word programmer for a fuse prom board
`timescale 1ns/100ps
`default_nettype none
module prom_word_programmer
  import prom_programmer_unit_pkg::*;
#(
  parameter int unsigned ONE_CYC  = ONE_BIT_CYC,
  parameter int unsigned HOLD_CY  = HOLD_CYC,
  parameter int unsigned ZERO_CY  = ZERO_BIT_CYC
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // io bus instruction strobes, same clock domain
  input  wire logic                 load_data_instr_i,
  input  wire logic                 load_address_instr_i,
  input  wire logic                 verify_read_instr_i,
  input  wire logic                 mask_out_i,
  input  wire logic [DEVCODE_W-1:0] sel_code_i,
  input  wire prom_programmer_unit_pkg::flag_fn_t flag_fn_i,
  input  wire logic [DATA_W-1:0]    bus_data_i,
  // jumpers, board data lines (asynchronous)
  input  wire logic [DEVCODE_W-1:0] dev_jumper_i,
  input  wire logic [DATA_W-1:0]    board_data_i,
  // host side answers
  output logic [DATA_W-1:0]         bus_data_o,
  output logic                      busy_o,
  output logic                      done_o,
  output logic                      irq_o,
  // prom board drive
  output logic [ADDR_W-1:0]         board_addr_o,
  output logic                      addr_valid_o,
  output logic [7:0]                bank_supply_o,
  output logic                      bit_drive_o,
  output logic [3:0]                bit_sel_o,
  output logic                      bank_enable_o
);
  import prom_programmer_unit_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_HOLD} state_t;
  localparam int unsigned CW = 24;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [DEVCODE_W-1:0] jmp_s1, jmp_s2;
  logic [DATA_W-1:0]    brd_s1, brd_s2;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      jmp_s1 <= '0;
      jmp_s2 <= '0;
      brd_s1 <= '0;
      brd_s2 <= '0;
    end else begin
      jmp_s1 <= dev_jumper_i;
      jmp_s2 <= jmp_s1;
      brd_s1 <= board_data_i;
      brd_s2 <= brd_s1;
    end
  end

  // jumper inserted reads as one
  logic sel;
  assign sel = (sel_code_i == jmp_s2);
  logic do_data, do_addr, do_rd, any_io;
  assign do_data = sel && load_data_instr_i;
  assign do_addr = sel && load_address_instr_i;
  assign do_rd   = sel && verify_read_instr_i;
  assign any_io  = do_data || do_addr || do_rd;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] shift_reg;
  logic [4:0]        bits_reg;
  state_t            state_reg;
  logic              busy_reg, done_reg, irq_en_reg;
  logic              start, step_end, load_t;
  logic [CW-1:0]     load_cnt;

  assign start = any_io && (flag_fn_i == FLAG_START) && !busy_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_reg <= '0;
    end else if (do_addr && !busy_reg) begin
      addr_reg <= bus_data_i[ADDR_W-1:ADDR_LSB];
    end
  end

  // host bit 15 is our msb, so a left shift exits ac bit 15 first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= '0;
    end else if (do_data && !busy_reg) begin
      shift_reg <= bus_data_i;
    end else if (state_reg == ST_STEP && step_end) begin
      shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic cur_one;
  assign cur_one = shift_reg[DATA_W-1];

  prom_bit_timer #(.CNT_W(CW)) u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (load_t),
    .count_i   (load_cnt),
    .expired_o (step_end)
  );

  logic step_go;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      bits_reg  <= '0;
      step_go   <= 1'b0;
    end else begin
      step_go <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_STEP;
            bits_reg  <= 5'd0;
            step_go   <= 1'b1;
          end
        end
        ST_STEP: begin
          if (step_end && !step_go) begin
            if (bits_reg == 5'(DATA_W - 1)) begin
              state_reg <= ST_HOLD;
              step_go   <= 1'b1;
            end else begin
              bits_reg <= bits_reg + 5'd1;
              step_go  <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (step_end && !step_go) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // a one bit takes the long pulse, a zero only its short slot
  assign load_t   = step_go;
  assign load_cnt = (state_reg == ST_HOLD) ? CW'(HOLD_CY) :
                    cur_one ? CW'(ONE_CYC) : CW'(ZERO_CY);

  // ----------------------------------------------------------------
  // flags; hardware set wins over a host clear
  // ----------------------------------------------------------------
  logic finish;
  assign finish = (state_reg == ST_STEP) && step_end && !step_go &&
                  (bits_reg == 5'(DATA_W - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (finish) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b1;
    end else if (any_io) begin
      unique case (flag_fn_i)
        FLAG_START: begin
          busy_reg <= 1'b1;
          done_reg <= 1'b0;
        end
        FLAG_CLEAR: begin
          busy_reg <= 1'b0;
          done_reg <= 1'b0;
        end
        FLAG_PULSE: done_reg <= 1'b0;
        FLAG_NONE:  done_reg <= done_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_reg <= 1'b1;
    end else begin
      irq_en_reg <= !mask_out_i;
    end
  end

  // verify path is combinational from the synchronised lines
  always_comb begin
    bus_data_o = do_rd ? brd_s2 : '0;
  end

  // ----------------------------------------------------------------
  // board drive
  // ----------------------------------------------------------------
  logic active;
  assign active        = (state_reg != ST_IDLE);
  assign board_addr_o  = addr_reg;
  assign addr_valid_o  = active;
  assign bit_drive_o   = (state_reg == ST_STEP) && cur_one;
  assign bit_sel_o     = bits_reg[3:0];
  assign bank_enable_o = (state_reg == ST_STEP) && cur_one &&
                         load_t;
  always_comb begin
    bank_supply_o = '0;
    if (state_reg == ST_STEP && cur_one) begin
      bank_supply_o[addr_reg[ADDR_W-1 -: BANK_W]] = 1'b1;
    end
  end
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign irq_o  = done_reg && irq_en_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_done_drops_busy;
    @(posedge clk_i) disable iff (rst_i)
    finish |=> done_reg && !busy_reg;
  endproperty
  a_done_drops_busy: assert property (p_done_drops_busy)
    else $error("done without busy drop");

  property p_start_sets_busy;
    @(posedge clk_i) disable iff (rst_i)
    start |=> busy_reg && !done_reg && state_reg == ST_STEP;
  endproperty
  a_start_sets_busy: assert property (p_start_sets_busy)
    else $error("start did not begin cycle");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
    any_io && flag_fn_i == FLAG_CLEAR && !finish |=> !busy_reg && !done_reg;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear failed");

  property p_pulse;
    @(posedge clk_i) disable iff (rst_i)
    any_io && flag_fn_i == FLAG_PULSE && !finish
      |=> !done_reg && busy_reg == $past(busy_reg);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse changed busy");

  property p_addr_load;
    @(posedge clk_i) disable iff (rst_i)
    do_addr && !busy_reg |=> addr_reg == $past(bus_data_i[ADDR_W-1:0]);
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("address load wrong");

  property p_data_load;
    @(posedge clk_i) disable iff (rst_i)
    do_data && !busy_reg |=> shift_reg == $past(bus_data_i);
  endproperty
  a_data_load: assert property (p_data_load)
    else $error("data load wrong");

  property p_hold_addr;
    @(posedge clk_i) disable iff (rst_i)
    finish |=> addr_valid_o && $stable(board_addr_o);
  endproperty
  a_hold_addr: assert property (p_hold_addr)
    else $error("address not held");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    irq_o == (done_o && !$past(mask_out_i));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq missing");

  property p_zero_fast;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == ST_STEP && step_go && !cur_one |-> ##[1:8] !step_go ##1
      (step_end || state_reg != ST_STEP);
  endproperty
  a_zero_fast: assert property (p_zero_fast)
    else $error("zero bit slow");
endmodule : prom_word_programmer
`default_nettype wire

/* prom_board_model.sv */
// prom board stand-in: counts fuse pulses, drives the data lines
`timescale 1ns/100ps
`default_nettype none
module prom_board_model (
  // drive from the programmer
  input  wire logic        clk_i,
  input  wire logic [11:0] board_addr_i,
  input  wire logic        addr_valid_i,
  input  wire logic [7:0]  bank_supply_i,
  input  wire logic        bit_drive_i,
  input  wire logic        bank_enable_i,
  input  wire logic [3:0]  bit_sel_i,
  // stored word and board lines
  input  wire logic [15:0] word_i,
  output logic [15:0]      data_o,
  output int               pulses_o,
  output int               bad_o
);
  // ------
  // fuse pulses and data lines
  // ------
  int unsigned tick;
  always_ff @(posedge clk_i) begin
    tick <= tick + 1;
    if (bank_enable_i && bit_drive_i) begin
      pulses_o <= pulses_o + 1;
      if (!addr_valid_i || !word_i[4'hF - bit_sel_i] ||
          bank_supply_i != 8'h01 << board_addr_i[11:9])
        bad_o <= bad_o + 1;
    end
  end
  // unselected lines float: a free-running cycle count, which can equal the old word
  assign data_o = addr_valid_i ? word_i : 16'(tick);
endmodule : prom_board_model
`default_nettype wire

/* tb_prom_word_programmer.sv */
// self-checking bench for the prom word programmer
`timescale 1ns/100ps
`default_nettype none
module tb_prom_word_programmer;
  import prom_programmer_unit_pkg::*;
  // ------
  // short counts keep the run brief
  // ------
  localparam int ONE = 20;
  localparam int HOLD = 10;
  localparam int ZER = 4;
  logic        clk, rst, ld_d, ld_a, vrf, mask, busy, done, irq, aval;
  logic        drv, ben;
  logic [5:0]  code, jmp;
  flag_fn_t    fn;
  logic [15:0] din, dout, word, rd, bdat;
  logic [11:0] addr;
  logic [7:0]  sup;
  logic [3:0]  bsel;
  int          pulses, bad, checked, num_errors, n, m;

  prom_word_programmer #(.ONE_CYC(ONE), .HOLD_CY(HOLD), .ZERO_CY(ZER)) u_dut (
    .clk_i(clk), .rst_i(rst), .load_data_instr_i(ld_d),
    .load_address_instr_i(ld_a), .verify_read_instr_i(vrf),
    .mask_out_i(mask), .sel_code_i(code), .flag_fn_i(fn), .bus_data_i(din),
    .dev_jumper_i(jmp), .board_data_i(bdat), .bus_data_o(dout),
    .busy_o(busy), .done_o(done), .irq_o(irq), .board_addr_o(addr),
    .addr_valid_o(aval), .bank_supply_o(sup), .bit_drive_o(drv),
    .bit_sel_o(bsel), .bank_enable_o(ben));

  prom_board_model u_board (
    .clk_i(clk), .board_addr_i(addr), .addr_valid_i(aval),
    .bank_supply_i(sup), .bit_drive_i(drv), .bank_enable_i(ben),
    .bit_sel_i(bsel),
    .word_i(word), .data_o(bdat), .pulses_o(pulses), .bad_o(bad));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one bus instruction; verify data is taken in the strobe cycle
  task automatic op(input int k, input logic [15:0] d, input flag_fn_t f,
                    input logic [5:0] c);
    @(posedge clk);
    ld_d <= (k == 0);
    ld_a <= (k == 1);
    vrf <= (k == 2);
    din <= d;
    fn <= f;
    code <= c;
    #10 rd = dout;
    @(posedge clk);
    ld_d <= 1'b0;
    ld_a <= 1'b0;
    vrf <= 1'b0;
    fn <= FLAG_NONE;
    #1;
  endtask : op

  // bounded wait for done high, or for the address to be released
  task automatic wt(input bit dn, output int c);
    c = 0;
    while (dn ? done !== 1'b1 : aval === 1'b1) begin
      @(posedge clk);
      #1 c++;
      if (c > 600) begin
        chk(16'h0000, 16'h0001);
        conclude();
      end
    end
  endtask : wt

  task automatic programmer_unit(input logic [15:0] a, d, input bit dfirst);
    int p0;
    int k;
    logic ok;
    p0 = pulses;
    k = $countones(d);
    word = d;
    if (dfirst) op(0, d, FLAG_NONE, 6'h05);
    op(1, a, dfirst ? FLAG_START : FLAG_NONE, 6'h05);
    if (!dfirst) op(0, d, FLAG_START, 6'h05);
    chk({15'h0, busy}, 16'h0001);
    wt(1'b1, n);
    ok = n >= k * ONE && n <= k * (ONE + 4) + (16 - k) * (ZER + 2) + 8;
    chk({15'h0, ok}, 16'h0001);
    chk(16'(pulses - p0), 16'(k));
    chk({4'h0, addr}, {4'h0, a[11:0]});
    chk({15'h0, busy}, 16'h0000);
    chk({15'h0, irq}, {15'h0, ~mask});
    op(2, 16'h0000, FLAG_PULSE, 6'h05);
    chk(rd, d);
    chk({15'h0, done}, 16'h0000);
    wt(1'b0, m);
    ok = m >= HOLD - 4 && m <= HOLD;
    chk({15'h0, ok}, 16'h0001);
  endtask : programmer_unit

  initial begin
    rst = 1'b1;
    {ld_d, ld_a, vrf, mask} = 4'h0;
    code = 6'h05;
    jmp = 6'h05;
    fn = FLAG_NONE;
    din = 16'h0000;
    word = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({12'h0, busy, done, irq, aval}, 16'h0000);
    chk(dout, 16'h0000);
    $display("test 1 over");
    programmer_unit(16'hF9A5, 16'h8001, 1'b0);
    $display("test 2 over");
    @(posedge clk);
    mask <= 1'b1;
    repeat (2) @(posedge clk);
    programmer_unit(16'h0FFF, 16'h0000, 1'b1);
    mask <= 1'b0;
    $display("test 3 over");
    // a cycle in progress refuses an address load and a second start
    word = 16'hFFFF;
    op(1, 16'h0123, FLAG_NONE, 6'h05);
    op(0, 16'hFFFF, FLAG_START, 6'h05);
    op(1, 16'h0456, FLAG_START, 6'h05);
    chk({4'h0, addr}, 16'h0123);
    op(2, 16'h0000, FLAG_PULSE, 6'h05);
    chk({15'h0, busy}, 16'h0001);
    op(2, 16'h0000, FLAG_CLEAR, 6'h05);
    chk({14'h0, busy, done}, 16'h0000);
    wt(1'b0, m);
    $display("test 4 over");
    op(0, 16'h0001, FLAG_START, 6'h06);
    chk({15'h0, busy}, 16'h0000);
    jmp <= 6'h06;
    repeat (3) @(posedge clk);
    op(1, 16'h0777, FLAG_NONE, 6'h06);
    op(1, 16'h0555, FLAG_NONE, 6'h05);
    chk({4'h0, addr}, 16'h0777);
    chk(16'(bad), 16'h0000);
    $display("test 5 over");
    conclude();
  end
endmodule : tb_prom_word_programmer
`default_nettype wire
